// >>> sprc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts for the sleep, power and reset block.
// Assumes: APB byte address is four times the register index.
// Notes: Definitions only.
`ifndef SPRC_CFG_SVH
`define SPRC_CFG_SVH
`define SPRC_IDX_SLEEP_MODE_CONTROL 10'h053
`define SPRC_IDX_POWER_REDUCTION    10'h064
`define SPRC_IDX_MICRO_CONTROL      10'h055
`define SPRC_IDX_STATUS             10'h056
`define SPRC_RST_SLEEP_MODE_CONTROL 8'h00
`define SPRC_RST_POWER_REDUCTION    8'h00
`define SPRC_RST_MICRO_CONTROL      8'h00
`define SPRC_SMC_WRITE_MASK         8'h0F
`define SPRC_PR_WRITE_MASK          8'hEF
`define SPRC_MC_PLAIN_MASK          8'h9F
`define SPRC_BIT_SLEEP_ENABLE       0
`define SPRC_BIT_GATE_CONVERTER     0
`define SPRC_BIT_GATE_SER_XCVR      1
`define SPRC_BIT_GATE_SER_PERIPH    2
`define SPRC_BIT_GATE_TIMER1        3
`define SPRC_BIT_GATE_TIMER0        5
`define SPRC_BIT_GATE_TIMER2        6
`define SPRC_BIT_GATE_TWO_WIRE      7
`define SPRC_BIT_BROWNOUT_OFF_UNLOCK 5
`define SPRC_BIT_BROWNOUT_OFF_SLEEP 6
`define SPRC_UNLOCK_CYCLES          3'h4
`define SPRC_BROWNOUT_OFF_IN_SLEEP_ACTIVE_AT         3'h3
`define SPRC_BROWNOUT_OFF_IN_SLEEP_LAST              3'h5
`define SPRC_BROWNOUT_FUSES_OFF     3'h7
`define SPRC_CLOCK_SELECT_FUSES_EXT_CLOCK        4'h0
`endif

// >>> sprc_pkg.sv
// Purpose: Types shared by the sleep, power and reset block.
// Assumes: Nothing beyond the cfg header.
// Notes: Types only.
`default_nettype none
package sprc_pkg;
   typedef enum logic [2:0] {
      SPRC_IDLE       = 3'h0,
      SPRC_NOISE_RED  = 3'h1,
      SPRC_POWER_DOWN = 3'h2,
      SPRC_POWER_SAVE = 3'h3,
      SPRC_RSVD4      = 3'h4,
      SPRC_RSVD5      = 3'h5,
      SPRC_STANDBY    = 3'h6,
      SPRC_EXT_STANDBY = 3'h7
   } sprc_mode_e;
   typedef enum logic [1:0] {
      SPRC_HOLD  = 2'h0,
      SPRC_COUNT = 2'h1,
      SPRC_RUN   = 2'h2
   } sprc_rst_e;
   typedef struct packed {
      logic two_wire;
      logic timer2;
      logic timer0;
      logic timer1;
      logic serial_periph;
      logic serial_transceiver;
      logic converter;
   } sprc_run_s;
endpackage : sprc_pkg
`default_nettype wire

// >>> sprc_ctrl.sv
// Purpose: Sleep mode selection, brown-out off in sleep, peripheral clock gating, reset stretching.
// Assumes: SLEEP_INSTR and WAKEUP are one-cycle pulses from the core; APB master as usual.
// Notes: Pin, power and brown-out resets act asynchronously, the watchdog on REF_CLK; release is counted on REF_CLK.
`timescale 1ns/1ps
`default_nettype none
`include "sprc_cfg.svh"
module sprc_ctrl #(
   parameter int CNT_W    = 16,
   parameter int TOUT0    = 16,
   parameter int TOUT1    = 256,
   parameter int TOUT2    = 1024,
   parameter int TOUT3    = 4096,
   parameter int TOUT_EXT = 8
) (
   input  wire logic                REF_CLK,
   input  wire logic                RESET_N,
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [11:0]         PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic [31:0]              PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   input  wire logic                SLEEP_INSTR,
   input  wire logic                WAKEUP,
   input  wire logic                TIMER2_ASYNC_SELECT,
   input  wire logic [1:0]          STARTUP_TIME_FUSES,
   input  wire logic [3:0]          CLOCK_SELECT_FUSES,
   input  wire logic                RESET_PIN_DISABLE_FUSE,
   input  wire logic [2:0]          BROWNOUT_LEVEL_FUSES,
   input  wire logic                POWER_OK,
   input  wire logic                EXT_RESET_PIN_N,
   input  wire logic                WATCHDOG_EXPIRE,
   input  wire logic                WATCHDOG_RESET_MODE,
   input  wire logic                BROWNOUT_LOW,
   output logic                     SLEEP_ACTIVE,
   output sprc_pkg::sprc_mode_e     SLEEP_MODE,
   output logic                     BROWNOUT_DETECTOR_OFF,
   output sprc_pkg::sprc_run_s      PERIPH_RUN,
   output logic                     COMPARATOR_MUX_ALLOW,
   output logic                     INTERNAL_RESET,
   output logic                     PORT_RESET_N,
   output logic                     CPU_START
);
   function automatic logic [CNT_W-1:0] tout_sel(input logic [1:0] startup_time_fuses, input logic [3:0] cks);
      logic [CNT_W-1:0] t;
      t = CNT_W'(TOUT0);
      if (cks == `SPRC_CLOCK_SELECT_FUSES_EXT_CLOCK) begin
         t = CNT_W'(TOUT_EXT);
      end else begin
         unique case (startup_time_fuses)
            2'h0: t = CNT_W'(TOUT0);
            2'h1: t = CNT_W'(TOUT1);
            2'h2: t = CNT_W'(TOUT2);
            2'h3: t = CNT_W'(TOUT3);
         endcase
      end
      return t;
   endfunction : tout_sel

   function automatic logic reserved_mode(input logic [2:0] m);
      return (m == sprc_pkg::SPRC_RSVD4) || (m == sprc_pkg::SPRC_RSVD5);
   endfunction : reserved_mode

   logic                 ext_low;
   logic                 bod_en;
   logic                 bod_low;
   logic                 rst_a_n;
   sprc_pkg::sprc_rst_e  state_q;
   sprc_pkg::sprc_rst_e  state_d;
   logic [CNT_W-1:0]     cnt_q;
   logic [CNT_W-1:0]     tout;
   logic                 wdt_hit;
   logic [3:0]           smc_q;
   logic [7:0]           pr_q;
   logic [7:0]           mc_q;
   logic                 brownout_off_in_sleep_q;
   logic [2:0]           brownout_off_in_sleep_cnt_q;
   logic [2:0]           unlock_q;
   logic                 brownout_off_in_sleep_active;
   logic                 sleeping_q;
   logic [2:0]           mode_q;
   logic                 bod_off_q;
   logic                 sys_rst_q;
   logic [9:0]           idx;
   logic                 hit_smc;
   logic                 hit_pr;
   logic                 hit_mc;
   logic                 hit_st;
   logic                 mapped;
   logic                 wr_go;
   logic [7:0]           rd_byte;
   logic                 sleep_ok;

   assign ext_low = ~EXT_RESET_PIN_N & ~RESET_PIN_DISABLE_FUSE;
   assign bod_en  = BROWNOUT_LEVEL_FUSES != `SPRC_BROWNOUT_FUSES_OFF;
   assign bod_low = bod_en & BROWNOUT_LOW;
   // RESET_N, POWER_OK, the pin or brown-out resets every flop at once, so ports reset with no clock running.
   assign rst_a_n = RESET_N & POWER_OK & ~ext_low & ~bod_low;
   assign tout    = tout_sel(STARTUP_TIME_FUSES, CLOCK_SELECT_FUSES);
   assign wdt_hit = WATCHDOG_EXPIRE & WATCHDOG_RESET_MODE;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sprc_pkg::SPRC_HOLD:  state_d = sprc_pkg::SPRC_COUNT;
         sprc_pkg::SPRC_COUNT: begin
            if (cnt_q >= tout - CNT_W'(1)) begin
               state_d = sprc_pkg::SPRC_RUN;
            end
         end
         sprc_pkg::SPRC_RUN: begin
            if (wdt_hit) begin
               state_d = sprc_pkg::SPRC_HOLD;
            end
         end
         default: state_d = sprc_pkg::SPRC_HOLD;
      endcase
   end

   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         state_q <= sprc_pkg::SPRC_HOLD;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= (state_q == sprc_pkg::SPRC_COUNT) ? cnt_q + CNT_W'(1) : '0;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         sys_rst_q      <= 1'b1;
         INTERNAL_RESET <= 1'b1;
         PORT_RESET_N   <= 1'b0;
         CPU_START      <= 1'b0;
      end else begin
         sys_rst_q      <= state_d != sprc_pkg::SPRC_RUN;
         INTERNAL_RESET <= state_d != sprc_pkg::SPRC_RUN;
         PORT_RESET_N   <= state_d == sprc_pkg::SPRC_RUN;
         CPU_START      <= (state_q == sprc_pkg::SPRC_COUNT) && (state_d == sprc_pkg::SPRC_RUN);
      end
   end

   assign idx     = PADDR[11:2];
   assign hit_smc = idx == `SPRC_IDX_SLEEP_MODE_CONTROL;
   assign hit_pr  = idx == `SPRC_IDX_POWER_REDUCTION;
   assign hit_mc  = idx == `SPRC_IDX_MICRO_CONTROL;
   assign hit_st  = idx == `SPRC_IDX_STATUS;
   assign mapped  = (hit_smc | hit_pr | hit_mc | hit_st) & (PADDR[1:0] == 2'h0);
   assign wr_go   = PSEL & PENABLE & PREADY & PWRITE & mapped;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_smc) begin
         rd_byte = {4'h0, smc_q};
      end else if (hit_pr) begin
         rd_byte = pr_q & `SPRC_PR_WRITE_MASK;
      end else if (hit_mc) begin
         rd_byte = (mc_q & `SPRC_MC_PLAIN_MASK) | {1'b0, brownout_off_in_sleep_q, unlock_q != 3'h0, 5'h00};
      end else if (hit_st) begin
         rd_byte = {2'h0, mode_q, brownout_off_in_sleep_active, bod_off_q, sleeping_q};
      end
   end

   // One wait state: PREADY rises in the second access cycle, writes land on the edge that ends it.
   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (PSEL && PENABLE && !PREADY) begin
         PREADY  <= 1'b1;
         PRDATA  <= (mapped && !PWRITE) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         PSLVERR <= !mapped;
      end else begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         smc_q <= 4'(`SPRC_RST_SLEEP_MODE_CONTROL);
         pr_q  <= `SPRC_RST_POWER_REDUCTION;
         mc_q  <= `SPRC_RST_MICRO_CONTROL;
      end else if (sys_rst_q) begin
         smc_q <= 4'(`SPRC_RST_SLEEP_MODE_CONTROL);
         pr_q  <= `SPRC_RST_POWER_REDUCTION;
         mc_q  <= `SPRC_RST_MICRO_CONTROL;
      end else if (wr_go) begin
         if (hit_smc) begin
            smc_q <= 4'(PWDATA[7:0] & `SPRC_SMC_WRITE_MASK);
         end
         if (hit_pr) begin
            pr_q <= PWDATA[7:0] & `SPRC_PR_WRITE_MASK;
         end
         if (hit_mc) begin
            mc_q <= PWDATA[7:0] & `SPRC_MC_PLAIN_MASK;
         end
      end
   end

   assign brownout_off_in_sleep_active = brownout_off_in_sleep_q & (brownout_off_in_sleep_cnt_q >= `SPRC_BROWNOUT_OFF_IN_SLEEP_ACTIVE_AT);

   // The unlock window is counted in cycles, so a slow second write simply fails.
   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         unlock_q   <= 3'h0;
         brownout_off_in_sleep_q     <= 1'b0;
         brownout_off_in_sleep_cnt_q <= 3'h0;
      end else if (sys_rst_q) begin
         unlock_q   <= 3'h0;
         brownout_off_in_sleep_q     <= 1'b0;
         brownout_off_in_sleep_cnt_q <= 3'h0;
      end else begin
         if (wr_go && hit_mc && PWDATA[`SPRC_BIT_BROWNOUT_OFF_UNLOCK]
             && PWDATA[`SPRC_BIT_BROWNOUT_OFF_SLEEP]) begin
            unlock_q <= `SPRC_UNLOCK_CYCLES;
         end else if (unlock_q != 3'h0) begin
            unlock_q <= unlock_q - 3'h1;
         end
         if (wr_go && hit_mc && (unlock_q != 3'h0) && PWDATA[`SPRC_BIT_BROWNOUT_OFF_SLEEP]
             && !PWDATA[`SPRC_BIT_BROWNOUT_OFF_UNLOCK]) begin
            brownout_off_in_sleep_q     <= 1'b1;
            brownout_off_in_sleep_cnt_q <= 3'h0;
         end else if (brownout_off_in_sleep_q) begin
            brownout_off_in_sleep_q     <= brownout_off_in_sleep_cnt_q != `SPRC_BROWNOUT_OFF_IN_SLEEP_LAST;
            brownout_off_in_sleep_cnt_q <= brownout_off_in_sleep_cnt_q + 3'h1;
         end
      end
   end

   assign sleep_ok = SLEEP_INSTR & smc_q[`SPRC_BIT_SLEEP_ENABLE]
                     & !reserved_mode(smc_q[3:1]) & !sleeping_q;

   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         sleeping_q <= 1'b0;
         mode_q     <= 3'h0;
         bod_off_q  <= 1'b0;
      end else if (sys_rst_q) begin
         sleeping_q <= 1'b0;
         mode_q     <= 3'h0;
         bod_off_q  <= 1'b0;
      end else if (sleep_ok) begin
         sleeping_q <= 1'b1;
         mode_q     <= smc_q[3:1];
         bod_off_q  <= brownout_off_in_sleep_active;
      end else if (WAKEUP) begin
         sleeping_q <= 1'b0;
         bod_off_q  <= 1'b0;
      end
   end

   assign SLEEP_ACTIVE          = sleeping_q;
   assign SLEEP_MODE            = sprc_pkg::sprc_mode_e'(mode_q);
   assign BROWNOUT_DETECTOR_OFF = bod_off_q;

   // Gating only stops the clock and access; peripheral state is kept, so ungating resumes.
   always_ff @(posedge REF_CLK or negedge rst_a_n) begin
      if (!rst_a_n) begin
         PERIPH_RUN           <= '1;
         COMPARATOR_MUX_ALLOW <= 1'b1;
      end else begin
         PERIPH_RUN.two_wire           <= !pr_q[`SPRC_BIT_GATE_TWO_WIRE];
         PERIPH_RUN.serial_periph      <= !pr_q[`SPRC_BIT_GATE_SER_PERIPH];
         PERIPH_RUN.serial_transceiver <= !pr_q[`SPRC_BIT_GATE_SER_XCVR];
         PERIPH_RUN.timer0             <= !pr_q[`SPRC_BIT_GATE_TIMER0];
         PERIPH_RUN.timer1             <= !pr_q[`SPRC_BIT_GATE_TIMER1];
         PERIPH_RUN.timer2             <= !(pr_q[`SPRC_BIT_GATE_TIMER2]
                                            && !TIMER2_ASYNC_SELECT);
         PERIPH_RUN.converter          <= !pr_q[`SPRC_BIT_GATE_CONVERTER];
         COMPARATOR_MUX_ALLOW          <= !pr_q[`SPRC_BIT_GATE_CONVERTER];
      end
   end

   property p_brownout_off_in_sleep_active_window;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      $rose(brownout_off_in_sleep_q) |-> !brownout_off_in_sleep_active [*3] ##1 brownout_off_in_sleep_active [*3] ##1 !brownout_off_in_sleep_q;
   endproperty
   a_brownout_off_in_sleep_active_window: assert property (p_brownout_off_in_sleep_active_window) else $error("brown-out sleep window wrong");

   sequence s_unlock_write;
      wr_go && hit_mc && PWDATA[6] && PWDATA[5];
   endsequence
   property p_brownout_off_in_sleep_needs_unlock;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      $rose(brownout_off_in_sleep_q) |-> $past(unlock_q) != 3'h0;
   endproperty
   a_brownout_off_in_sleep_needs_unlock: assert property (p_brownout_off_in_sleep_needs_unlock) else $error("bit set without unlock");

   property p_unlock_expires;
      @(posedge REF_CLK) disable iff (!rst_a_n || sys_rst_q)
      s_unlock_write ##1 !(wr_go && hit_mc) [*4] |=> unlock_q == 3'h0;
   endproperty
   a_unlock_expires: assert property (p_unlock_expires) else $error("unlock window too long");

   property p_no_sleep_without_enable;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      $rose(sleeping_q) |-> $past(smc_q[0]) && !reserved_mode($past(smc_q[3:1]));
   endproperty
   a_no_sleep_without_enable: assert property (p_no_sleep_without_enable) else $error("bad sleep entry");
   property p_bod_off_cause;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      $rose(bod_off_q) |-> $past(brownout_off_in_sleep_active) && $rose(sleeping_q);
   endproperty
   a_bod_off_cause: assert property (p_bod_off_cause) else $error("detector off without cause");
   property p_smc_upper_zero;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      PREADY && hit_smc && !PWRITE |-> PRDATA[31:4] == 28'h000_0000;
   endproperty
   a_smc_upper_zero: assert property (p_smc_upper_zero) else $error("sleep control upper bits");
   property p_pr_bit4_zero;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      PREADY && hit_pr && !PWRITE |-> !PRDATA[4];
   endproperty
   a_pr_bit4_zero: assert property (p_pr_bit4_zero) else $error("power reduction bit 4 set");
   property p_timer2_async;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      pr_q[6] && TIMER2_ASYNC_SELECT |=> PERIPH_RUN.timer2;
   endproperty
   a_timer2_async: assert property (p_timer2_async) else $error("async timer 2 stopped");
   property p_comparator_block;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      pr_q[0] |=> !COMPARATOR_MUX_ALLOW && !PERIPH_RUN.converter;
   endproperty
   a_comparator_block: assert property (p_comparator_block) else $error("mux used while gated");
   property p_wdt_pulse;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      state_q == sprc_pkg::SPRC_RUN && wdt_hit |=> INTERNAL_RESET ##1 state_q == sprc_pkg::SPRC_COUNT;
   endproperty
   a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset sequence");

   property p_release_after_count;
      @(posedge REF_CLK) disable iff (!rst_a_n)
      $fell(INTERNAL_RESET) |-> $past(cnt_q) == tout - CNT_W'(1) && CPU_START;
   endproperty
   a_release_after_count: assert property (p_release_after_count) else $error("early release");
endmodule : sprc_ctrl
`default_nettype wire

// >>> tb_sprc.sv
// Purpose: Self-checking bench for the sleep, power and reset block.
// Assumes: Registers answer over APB; reset delays are shortened by parameter.
// Notes: Reset sources change just after an edge, so the clockless effect of pin, power and brown-out shows before the next.
`timescale 1ns/1ps
`default_nettype none
`include "sprc_cfg.svh"
module tb_top;
   localparam int TOUT = 6;
   localparam int TOUT1 = 7;
   localparam int TOUT2 = 8;
   localparam int TOUT3 = 9;
   localparam int TOUT_X = 5;
   localparam logic [11:0] A_SMC = {`SPRC_IDX_SLEEP_MODE_CONTROL, 2'b00};
   localparam logic [11:0] A_PR  = {`SPRC_IDX_POWER_REDUCTION, 2'b00};
   localparam logic [11:0] A_MC  = {`SPRC_IDX_MICRO_CONTROL, 2'b00};
   localparam logic [11:0] A_ST  = {`SPRC_IDX_STATUS, 2'b00};
   logic                 clk, rst_n, psel, pen, pwr, slp, wake, as2, rpd, pok, pin_n, wde, wdm;
   logic                 bol, pready, pslverr, sact, bodoff, mux_ok, irst, prst_n, cpu_go, erb;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic [2:0]           bfuse;
   sprc_pkg::sprc_mode_e smode;
   sprc_pkg::sprc_run_s  prun;
   int                   err_total, checks_done, cyc;
   logic [1:0]           startup_time_fuses;
   logic [3:0]           cks;
   int                   tref;

   sprc_ctrl #(.TOUT0(TOUT), .TOUT1(TOUT1), .TOUT2(TOUT2), .TOUT3(TOUT3),
               .TOUT_EXT(TOUT_X)) u_sprc_ctrl (
      .REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SLEEP_INSTR(slp), .WAKEUP(wake), .TIMER2_ASYNC_SELECT(as2),
      .STARTUP_TIME_FUSES(startup_time_fuses), .CLOCK_SELECT_FUSES(cks), .RESET_PIN_DISABLE_FUSE(rpd),
      .BROWNOUT_LEVEL_FUSES(bfuse), .POWER_OK(pok), .EXT_RESET_PIN_N(pin_n),
      .WATCHDOG_EXPIRE(wde), .WATCHDOG_RESET_MODE(wdm), .BROWNOUT_LOW(bol),
      .SLEEP_ACTIVE(sact), .SLEEP_MODE(smode), .BROWNOUT_DETECTOR_OFF(bodoff),
      .PERIPH_RUN(prun), .COMPARATOR_MUX_ALLOW(mux_ok), .INTERNAL_RESET(irst),
      .PORT_RESET_N(prst_n), .CPU_START(cpu_go));

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // The request is held until pready is seen high at an edge; only then released.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      erb = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask : rdchk

   // Called just after a release; counts edges until the stretched reset ends.
   // A source release costs two edges more than a watchdog hold, which already counts.
   task automatic wait_rel(input string nm, input int extra);
      int n;
      n = 0;
      while (irst === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk({nm, " cpu_start"}, cpu_go, 1'b1);
      chk({nm, " delay"}, n, tref + extra);
   endtask : wait_rel

   task automatic t_src(input int k, input logic hit, input string nm);
      apb(1'b1, A_PR, 32'h0000_0003);
      @(posedge clk);
      case (k)
         0: pin_n <= 1'b0;
         1: pok <= 1'b0;
         2: bol <= 1'b1;
         3: wdm <= 1'b1;
         default: ;
      endcase
      if (k >= 3) wde <= 1'b1;
      #1;
      if (k >= 3) begin
         @(posedge clk);
         wde <= 1'b0;
         @(posedge clk);
      end
      chk({nm, " reset"}, irst, hit);
      chk({nm, " port"}, prst_n, !hit);
      @(posedge clk);
      pin_n <= 1'b1;
      pok   <= 1'b1;
      bol   <= 1'b0;
      wdm   <= 1'b0;
      if (hit) wait_rel(nm, (k == 3) ? 0 : 2);
      rdchk(A_PR, hit ? 32'h0 : 32'h3, {nm, " regs"});
   endtask : t_src

   // The fuses pick the stretch length; a pin pulse then measures it.
   task automatic t_fuse(input logic [1:0] s, input logic [3:0] c, input int t, input string nm);
      @(posedge clk);
      startup_time_fuses  <= s;
      cks  <= c;
      tref = t;
      t_src(0, 1'b1, nm);
   endtask : t_fuse

   task automatic t_regs;
      rdchk(A_SMC, 32'h0, "smc init");
      rdchk(A_MC, 32'h0, "mc init");
      apb(1'b1, A_SMC, 32'hFFFF_FFFF);
      rdchk(A_SMC, 32'h0F, "smc upper");
      apb(1'b1, A_PR, 32'h0000_00FF);
      rdchk(A_PR, 32'hEF, "pr bit4");
      repeat (2) @(posedge clk);
      chk("run gated", prun, 7'h00);
      chk("mux gated", mux_ok, 1'b0);
      as2 <= 1'b1;
      repeat (3) @(posedge clk);
      chk("run async", prun, 7'h20);
      apb(1'b1, A_PR, 32'h0);
      repeat (2) @(posedge clk);
      chk("run back", prun, 7'h7F);
      chk("mux back", mux_ok, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped err", erb, 1'b1);
      chk("unmapped data", rd, 32'h0);
   endtask : t_regs

   task automatic t_sleep_pulse;
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(posedge clk);
   endtask : t_sleep_pulse

   task automatic t_wake;
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(posedge clk);
      chk("awake", sact, 1'b0);
   endtask : t_wake

   task automatic t_modes;
      logic hit;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, A_SMC, {28'h0, m[2:0], 1'b1});
         t_sleep_pulse();
         hit = !(m == 4 || m == 5);
         chk("sleep mode", sact, hit);
         if (hit) chk("mode out", smode, m[2:0]);
         if (hit) rdchk(A_ST, {26'h0, m[2:0], 3'b001}, "status mode");
         t_wake();
      end
      apb(1'b1, A_SMC, 32'h0000_0004);
      t_sleep_pulse();
      chk("no enable", sact, 1'b0);
   endtask : t_modes

   // Unlock then set; the sleep lands dly+1 edges after the set commits.
   task automatic t_brownout_off_in_sleep(input int gap, input int dly, input logic exp, input string nm);
      apb(1'b1, A_SMC, 32'h0000_0005);
      apb(1'b1, A_MC, 32'h0000_0060);
      repeat (gap) @(posedge clk);
      apb(1'b1, A_MC, 32'h0000_0040);
      repeat (dly) @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      @(posedge clk);
      chk({nm, " off"}, bodoff, exp);
      chk({nm, " sleep"}, sact, 1'b1);
      t_wake();
      rdchk(A_MC, 32'h0, {nm, " cleared"});
   endtask : t_brownout_off_in_sleep

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         stop_test();
      end
   end

   initial begin
      {rst_n, psel, pen, pwr, slp, wake, as2, rpd, wde, wdm, bol} = '0;
      {pok, pin_n} = 2'b11;
      paddr = '0;
      pwdata = '0;
      bfuse = 3'h0;
      err_total = 0;
      checks_done = 0;
      cyc = 0;
      startup_time_fuses = 2'h0;
      cks = 4'h1;
      tref = TOUT;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      wait_rel("start", 2);
      t_regs();
      t_modes();
      t_brownout_off_in_sleep(0, 3, 1'b1, "brownout_off_in_sleep on");
      t_brownout_off_in_sleep(0, 0, 1'b0, "brownout_off_in_sleep early");
      t_brownout_off_in_sleep(0, 6, 1'b0, "brownout_off_in_sleep late");
      t_brownout_off_in_sleep(4, 3, 1'b0, "brownout_off_in_sleep window");
      t_src(0, 1'b1, "pin");
      rpd <= 1'b1;
      t_src(0, 1'b0, "pin off");
      rpd <= 1'b0;
      t_src(1, 1'b1, "power");
      t_src(2, 1'b1, "brownout");
      bfuse <= `SPRC_BROWNOUT_FUSES_OFF;
      t_src(2, 1'b0, "brownout off");
      t_src(3, 1'b1, "watchdog");
      t_src(4, 1'b0, "watchdog irq");
      t_fuse(2'h1, 4'h1, TOUT1, "fuse one");
      t_fuse(2'h2, 4'h1, TOUT2, "fuse two");
      t_fuse(2'h3, 4'h1, TOUT3, "fuse three");
      t_fuse(2'h3, 4'h0, TOUT_X, "fuse ext");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
